// >>> twfo_top.sv
// 16-bit timer counter with compare channel A waveform output and pin override.
// Assumes an APB master on core_clk and port pin logic that resolves the pad.
//
// Summary of operation
// - Nonzero output mode replaces port data on pin
// - Direction bit alone still enables the pin
// - Reset clears the internal output state
// - Output mode zero leaves state unchanged on match
// - New mode acts at next match; force acts now
// - Output mode never touches capture register
// - Waveform mode alone sets the counting sequence
// - Normal mode counts up and wraps at max
// - Normal overflow flag set as count becomes zero
// - Software may write the count any time
// - Clear-on-match clears at compare A or capture top
// - Clear-on-match top unbuffered; missed match wraps
// - Reaching top sets compare A or capture flag
// - Toggle mode flips channel A on each match
// - Prescaler divides by 1, 8, 64, 256, 1024
// - Clear-on-match overflow flag set on max wrap
// - Modes 5,6,7,14,15 are single-slope fast PWM
// - Non-inverting sets on match, clears at top
// - Fast PWM tops fixed, capture or compare A
// - Fast PWM buffers compare A until top
// - Mode two non-inverted, mode three inverted PWM
// - Force updates output outside fast PWM, without flag or reload
//
// Implementation choices: the address map and the APB register port.
module twfo_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port pin
    output logic portPinOut,
    output logic portPinOe
);

    twfo_pkg::twfo_ctrl_s ctrl_ff;
    logic [15:0] timerCount_ff;
    logic [15:0] compareValueA_ff;
    logic [15:0] compareBufferA_ff;
    logic [15:0] captureTop_ff;
    logic overflowFlag_ff;
    logic compareAFlag_ff;
    logic captureFlag_ff;
    logic channelAOutputState_ff;
    logic portDataBit_ff;
    logic outputPinDirectionBit_ff;
    logic blockMatch_ff;
    logic [31:0] prdata_ff;
    logic timerTick;
    logic wrEn;
    logic mapped;
    logic isFast;
    logic isCtc;
    logic [15:0] topValue;
    logic atTop;
    logic matchA;
    logic wrapMax;
    logic forceA;
    logic nxt_state;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode shared by counter, flags and output logic

    // Decode depends on the waveform mode field only
    function automatic logic fastMode(input twfo_pkg::twfo_wgm_t m);
        return m inside {twfo_pkg::WGM_FAST_8, twfo_pkg::WGM_FAST_9, twfo_pkg::WGM_FAST_10,
                         twfo_pkg::WGM_FAST_CAP, twfo_pkg::WGM_FAST_CMPA};
    endfunction

    // Write strobe for one register address
    function automatic logic regWrite(input logic en, input logic [7:0] a, input logic [7:0] r);
        return en && (a == r);
    endfunction

    assign isFast = fastMode(ctrl_ff.wgm);
    assign isCtc = (ctrl_ff.wgm == twfo_pkg::WGM_CTC_CMPA) || (ctrl_ff.wgm == twfo_pkg::WGM_CTC_CAP);

    // Top selection from the waveform mode field
    always_comb begin
        topValue = twfo_pkg::CNT_MAX;
        unique case (ctrl_ff.wgm)
            twfo_pkg::WGM_CTC_CMPA: topValue = compareValueA_ff;
            twfo_pkg::WGM_CTC_CAP: topValue = captureTop_ff;
            twfo_pkg::WGM_FAST_8: topValue = twfo_pkg::TOP_8BIT;
            twfo_pkg::WGM_FAST_9: topValue = twfo_pkg::TOP_9BIT;
            twfo_pkg::WGM_FAST_10: topValue = twfo_pkg::TOP_10BIT;
            twfo_pkg::WGM_FAST_CAP: topValue = captureTop_ff;
            twfo_pkg::WGM_FAST_CMPA: topValue = compareValueA_ff;
            default: topValue = twfo_pkg::CNT_MAX;
        endcase
    end

    // Equality only: a top written below the count is passed over until wrap
    assign atTop = (isCtc || isFast) && (timerCount_ff == topValue);
    assign wrapMax = timerCount_ff == twfo_pkg::CNT_MAX;
    // A count write blocks the match of the following timer cycle
    assign matchA = (timerCount_ff == compareValueA_ff) && !blockMatch_ff;

    twfo_prescaler u_prescaler (
        .core_clk(core_clk),
        .resetn(resetn),
        .clkSel(ctrl_ff.clkSel),
        .timerTick(timerTick)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup phase
    assign wrEn = psel && penable && pwrite;
    assign mapped = paddr inside {twfo_pkg::ADDR_CTRL, twfo_pkg::ADDR_COUNT, twfo_pkg::ADDR_CMPA,
                    twfo_pkg::ADDR_CAPTOP, twfo_pkg::ADDR_FLAGS, twfo_pkg::ADDR_FORCE, twfo_pkg::ADDR_PORT};
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_ff;
    assign forceA = regWrite(wrEn, paddr, twfo_pkg::ADDR_FORCE) && pwdata[twfo_pkg::FRC_A] && !isFast;

    // Read mux; unmapped addresses read zero, write cycles keep the last read data
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                twfo_pkg::ADDR_CTRL: prdata_ff <= {21'h000000, ctrl_ff.clkSel, 2'h0, ctrl_ff.com, ctrl_ff.wgm};
                twfo_pkg::ADDR_COUNT: prdata_ff <= {16'h0000, timerCount_ff};
                twfo_pkg::ADDR_CMPA: prdata_ff <= {16'h0000, isFast ? compareBufferA_ff : compareValueA_ff};
                twfo_pkg::ADDR_CAPTOP: prdata_ff <= {16'h0000, captureTop_ff};
                twfo_pkg::ADDR_FLAGS: prdata_ff <= {29'h00000000, captureFlag_ff, compareAFlag_ff, overflowFlag_ff};
                twfo_pkg::ADDR_PORT: prdata_ff <= {30'h00000000, outputPinDirectionBit_ff, portDataBit_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Control and port registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= twfo_pkg::CTRL_RESET;
            portDataBit_ff <= 1'b0;
            outputPinDirectionBit_ff <= 1'b0;
        end else begin
            if (regWrite(wrEn, paddr, twfo_pkg::ADDR_CTRL)) begin
                // Output mode is not buffered: used from the next match on
                ctrl_ff.wgm <= pwdata[twfo_pkg::CTRL_WGM_LSB +: 4];
                ctrl_ff.com <= twfo_pkg::twfo_com_e'(pwdata[twfo_pkg::CTRL_COM_LSB +: 2]);
                ctrl_ff.clkSel <= twfo_pkg::twfo_cs_e'(pwdata[twfo_pkg::CTRL_CS_LSB +: 3]);
            end
            if (regWrite(wrEn, paddr, twfo_pkg::ADDR_PORT)) begin
                portDataBit_ff <= pwdata[twfo_pkg::PORT_DATA];
                outputPinDirectionBit_ff <= pwdata[twfo_pkg::PORT_DIR];
            end
        end
    end

    // Capture top is written only by software; no capture event reaches it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            captureTop_ff <= twfo_pkg::CNT_ZERO;
        end else if (regWrite(wrEn, paddr, twfo_pkg::ADDR_CAPTOP)) begin
            captureTop_ff <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter: software write wins over a timer tick in the same cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timerCount_ff <= twfo_pkg::CNT_ZERO;
        end else if (regWrite(wrEn, paddr, twfo_pkg::ADDR_COUNT)) begin
            timerCount_ff <= pwdata[15:0];
        end else if (timerTick) begin
            if (atTop) begin
                timerCount_ff <= twfo_pkg::CNT_ZERO;
            end else begin
                timerCount_ff <= timerCount_ff + 16'h0001;
            end
        end
    end

    // Match blocking: armed by a count write, spent by the next tick
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            blockMatch_ff <= 1'b0;
        end else if (regWrite(wrEn, paddr, twfo_pkg::ADDR_COUNT)) begin
            blockMatch_ff <= 1'b1;
        end else if (timerTick) begin
            blockMatch_ff <= 1'b0;
        end
    end

    // Compare A: direct in non-PWM modes, buffered to top in fast PWM
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            compareValueA_ff <= twfo_pkg::CNT_ZERO;
            compareBufferA_ff <= twfo_pkg::CNT_ZERO;
        end else begin
            if (regWrite(wrEn, paddr, twfo_pkg::ADDR_CMPA)) begin
                compareBufferA_ff <= pwdata[15:0];
            end
            if (regWrite(wrEn, paddr, twfo_pkg::ADDR_CMPA) && !isFast) begin
                compareValueA_ff <= pwdata[15:0];
            end else if (isFast && timerTick && atTop) begin
                compareValueA_ff <= compareBufferA_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: hardware only sets, software clears by writing one; set wins
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            overflowFlag_ff <= 1'b0;
            compareAFlag_ff <= 1'b0;
            captureFlag_ff <= 1'b0;
        end else begin
            if (timerTick && ((isFast && atTop) || (!isFast && wrapMax))) begin
                overflowFlag_ff <= 1'b1;
            end else if (regWrite(wrEn, paddr, twfo_pkg::ADDR_FLAGS) && pwdata[twfo_pkg::FLG_OVF]) begin
                overflowFlag_ff <= 1'b0;
            end
            // Forced compares never reach this flag
            if (timerTick && matchA) begin
                compareAFlag_ff <= 1'b1;
            end else if (regWrite(wrEn, paddr, twfo_pkg::ADDR_FLAGS) && pwdata[twfo_pkg::FLG_CMPA]) begin
                compareAFlag_ff <= 1'b0;
            end
            if (timerTick && atTop && (topValue == captureTop_ff)
                && (ctrl_ff.wgm inside {twfo_pkg::WGM_CTC_CAP, twfo_pkg::WGM_FAST_CAP})) begin
                captureFlag_ff <= 1'b1;
            end else if (regWrite(wrEn, paddr, twfo_pkg::ADDR_FLAGS) && pwdata[twfo_pkg::FLG_CAP]) begin
                captureFlag_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output state: top action first, then a match overrides it so that
    // compare equal to top gives a constant level in fast PWM clear and set modes
    always_comb begin
        nxt_state = channelAOutputState_ff;
        if (forceA) begin
            unique case (ctrl_ff.com)
                twfo_pkg::COM_TOGGLE: nxt_state = !channelAOutputState_ff;
                twfo_pkg::COM_CLEAR: nxt_state = 1'b0;
                twfo_pkg::COM_SET: nxt_state = 1'b1;
                twfo_pkg::COM_OFF: nxt_state = channelAOutputState_ff;
            endcase
        end else if (timerTick) begin
            if (isFast && atTop) begin
                if (ctrl_ff.com == twfo_pkg::COM_CLEAR) begin
                    nxt_state = 1'b0;
                end else if (ctrl_ff.com == twfo_pkg::COM_SET) begin
                    nxt_state = 1'b1;
                end
            end
            if (matchA) begin
                unique case (ctrl_ff.com)
                    twfo_pkg::COM_TOGGLE: nxt_state = !channelAOutputState_ff;
                    twfo_pkg::COM_CLEAR: nxt_state = isFast ? 1'b1 : 1'b0;
                    twfo_pkg::COM_SET: nxt_state = isFast ? 1'b0 : 1'b1;
                    twfo_pkg::COM_OFF: nxt_state = channelAOutputState_ff;
                endcase
            end
        end
    end

    // State kept across mode changes; reset only by the system reset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            channelAOutputState_ff <= 1'b0;
        end else begin
            channelAOutputState_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin override multiplexer; direction never overridden
    assign portPinOut = (ctrl_ff.com != twfo_pkg::COM_OFF) ? channelAOutputState_ff : portDataBit_ff;
    assign portPinOe = outputPinDirectionBit_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_pin_override: assert property (@(posedge core_clk) disable iff (!resetn)
        (ctrl_ff.com != twfo_pkg::COM_OFF) |-> (portPinOut == channelAOutputState_ff)
            && (portPinOe == outputPinDirectionBit_ff))
        else $error("pin not driven by output state");

    a_state_reset: assert property (@(posedge core_clk)
        $rose(resetn) |-> !channelAOutputState_ff)
        else $error("output state not cleared by reset");

    a_mode_zero_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        (ctrl_ff.com == twfo_pkg::COM_OFF) && $stable(ctrl_ff.com) |=> $stable(channelAOutputState_ff))
        else $error("state changed with output mode zero");

    a_normal_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
        timerTick && (ctrl_ff.wgm == twfo_pkg::WGM_NORMAL) && wrapMax && !wrEn
            |=> (timerCount_ff == twfo_pkg::CNT_ZERO) && overflowFlag_ff)
        else $error("normal mode wrap or overflow flag wrong");

    a_ctc_clear: assert property (@(posedge core_clk) disable iff (!resetn)
        timerTick && isCtc && (timerCount_ff == topValue) && !wrEn |=> timerCount_ff == twfo_pkg::CNT_ZERO)
        else $error("clear on match missed");

    a_ctc_toggle: assert property (@(posedge core_clk) disable iff (!resetn)
        timerTick && isCtc && matchA && (ctrl_ff.com == twfo_pkg::COM_TOGGLE) && !wrEn
            |=> channelAOutputState_ff != $past(channelAOutputState_ff))
        else $error("toggle on match missing");

    a_fast_restart: assert property (@(posedge core_clk) disable iff (!resetn)
        timerTick && isFast && atTop && !wrEn
            |=> (timerCount_ff == twfo_pkg::CNT_ZERO) && overflowFlag_ff)
        else $error("fast PWM did not restart at top");

    a_count_write: assert property (@(posedge core_clk) disable iff (!resetn)
        regWrite(wrEn, paddr, twfo_pkg::ADDR_COUNT) |=> timerCount_ff == 16'($past(pwdata)))
        else $error("count write not taken");

    a_ctc_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
        timerTick && isCtc && wrapMax && !atTop && !wrEn
            |=> (timerCount_ff == twfo_pkg::CNT_ZERO) && overflowFlag_ff)
        else $error("clear-on-match wrap or overflow flag wrong");

    a_port_data: assert property (@(posedge core_clk) disable iff (!resetn)
        (ctrl_ff.com == twfo_pkg::COM_OFF) |-> portPinOut == portDataBit_ff)
        else $error("pin not driven by port data");

    a_buffer_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        isFast && !(timerTick && atTop) |=> $stable(compareValueA_ff))
        else $error("compare A changed away from top");

    a_force_noflag: assert property (@(posedge core_clk) disable iff (!resetn)
        forceA && !timerTick && !compareAFlag_ff |=> !compareAFlag_ff && $stable(timerCount_ff))
        else $error("force touched flag or counter");

endmodule

// >>> twfo_pkg.sv
// Shared constants and types for the 16-bit timer waveform output block.
// Assumes one 125 MHz system clock and a 32-bit APB register port.
package twfo_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Counter values and fixed tops
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;

    ////////////////////////////////////////////////////////////////////////
    // Waveform mode codes (other codes count like normal mode)
    typedef logic [3:0] twfo_wgm_t;
    localparam twfo_wgm_t WGM_NORMAL = 4'h0;
    localparam twfo_wgm_t WGM_CTC_CMPA = 4'h4;
    localparam twfo_wgm_t WGM_FAST_8 = 4'h5;
    localparam twfo_wgm_t WGM_FAST_9 = 4'h6;
    localparam twfo_wgm_t WGM_FAST_10 = 4'h7;
    localparam twfo_wgm_t WGM_CTC_CAP = 4'hC;
    localparam twfo_wgm_t WGM_FAST_CAP = 4'hE;
    localparam twfo_wgm_t WGM_FAST_CMPA = 4'hF;

    // Compare output mode field
    typedef enum logic [1:0] {
        COM_OFF = 2'h0,
        COM_TOGGLE = 2'h1,
        COM_CLEAR = 2'h2,
        COM_SET = 2'h3
    } twfo_com_e;

    // Prescaler select; codes above DIV1024 stop the timer
    typedef enum logic [2:0] {
        CS_STOP = 3'h0,
        CS_DIV1 = 3'h1,
        CS_DIV8 = 3'h2,
        CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4,
        CS_DIV1024 = 3'h5,
        CS_RSVD6 = 3'h6,
        CS_RSVD7 = 3'h7
    } twfo_cs_e;

    // Prescaler phase masks: tick when the low bits are all ones
    localparam logic [9:0] MASK_DIV1 = 10'h000;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV64 = 10'h03F;
    localparam logic [9:0] MASK_DIV256 = 10'h0FF;
    localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

    // Control register contents
    typedef struct packed {
        twfo_cs_e clkSel;
        twfo_com_e com;
        twfo_wgm_t wgm;
    } twfo_ctrl_s;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses and field positions
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_CMPA = 8'h08;
    localparam logic [7:0] ADDR_CAPTOP = 8'h0C;
    localparam logic [7:0] ADDR_FLAGS = 8'h10;
    localparam logic [7:0] ADDR_FORCE = 8'h14;
    localparam logic [7:0] ADDR_PORT = 8'h18;
    localparam int CTRL_WGM_LSB = 0;
    localparam int CTRL_COM_LSB = 4;
    localparam int CTRL_CS_LSB = 8;
    localparam int FLG_OVF = 0;
    localparam int FLG_CMPA = 1;
    localparam int FLG_CAP = 2;
    localparam int FRC_A = 0;
    localparam int PORT_DATA = 0;
    localparam int PORT_DIR = 1;
    localparam twfo_ctrl_s CTRL_RESET = '{clkSel: CS_STOP, com: COM_OFF, wgm: WGM_NORMAL};

endpackage

// >>> twfo_prescaler.sv
// Timer clock enable generator: one core_clk pulse per N system clocks.
// Assumes the select comes from a register on the same clock.
module twfo_prescaler (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Divisor select
    input wire twfo_pkg::twfo_cs_e clkSel,
    // Timer clock enable pulse
    output logic timerTick
);

    logic [9:0] phase_ff;
    logic [9:0] mask;

    ////////////////////////////////////////////////////////////////////////
    // Free-running phase; shared by all divisors so a change of divisor
    // costs at most one partial period
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            phase_ff <= 10'h000;
        end else begin
            phase_ff <= phase_ff + 10'h001;
        end
    end

    // Divisor one of 1, 8, 64, 256 or 1024
    always_comb begin
        mask = twfo_pkg::MASK_DIV1;
        unique case (clkSel)
            twfo_pkg::CS_DIV8: mask = twfo_pkg::MASK_DIV8;
            twfo_pkg::CS_DIV64: mask = twfo_pkg::MASK_DIV64;
            twfo_pkg::CS_DIV256: mask = twfo_pkg::MASK_DIV256;
            twfo_pkg::CS_DIV1024: mask = twfo_pkg::MASK_DIV1024;
            default: mask = twfo_pkg::MASK_DIV1;
        endcase
    end

    // Stopped and reserved selects give no tick
    assign timerTick = (clkSel inside {twfo_pkg::CS_DIV1, twfo_pkg::CS_DIV8, twfo_pkg::CS_DIV64,
                        twfo_pkg::CS_DIV256, twfo_pkg::CS_DIV1024}) && ((phase_ff & mask) == mask);

endmodule

// >>> twfo_pin_model.sv
// Port pin model: resolves the pad from the block's pin value and enable.
// Assumes no pull on the pad, so an undriven pad shows the inverse of its last level.
module twfo_pin_model (
    // Clock
    input wire logic core_clk,
    // Block side
    input wire logic portPinOut,
    input wire logic portPinOe,
    // Pad
    output logic padLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lastLevel_ff;

    ////////////////////////////////////////////////////////////////////////
    // Remember the last level that was really driven
    always_ff @(posedge core_clk) begin
        if (portPinOe) begin
            lastLevel_ff <= portPinOut;
        end
    end

    // An undriven pad never echoes the old value, so a lost enable shows up
    assign padLevel = portPinOe ? portPinOut : ~lastLevel_ff;
endmodule

// >>> timer16_waveform_output_bench.sv
// Bench for the timer waveform output block: pin mux, force, counting and PWM.
// Assumes a zero-wait APB slave and the pin model on the far side.
module timer16_waveform_output_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, portPinOut, portPinOe, padLevel, err;
    int fail_count = 0;
    int cmp_count = 0;
    int hi, lo;

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and pin model
    always #4 core_clk = ~core_clk;
    twfo_top twfo_top_i (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .portPinOut(portPinOut), .portPinOe(portPinOe));
    twfo_pin_model twfo_pin_model_i (.core_clk(core_clk), .portPinOut(portPinOut), .portPinOe(portPinOe),
        .padLevel(padLevel));

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic stop_test();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] ctrl(input logic [2:0] cs, input logic [1:0] com, input logic [3:0] wgm);
        return {21'h0, cs, 2'h0, com, wgm};
    endfunction
    // Request is held until the edge where pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the access edge settle before callers look at outputs
        @(negedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask
    // Stopped and in normal mode while loading, so compare A is written direct
    task automatic setup(input logic [3:0] m, input logic [1:0] com, input logic [2:0] cs,
        input logic [15:0] cmp, input logic [15:0] top, input logic [15:0] cnt);
        wr(twfo_pkg::ADDR_CTRL, ctrl(3'h0, com, 4'h0));
        wr(twfo_pkg::ADDR_CMPA, {16'h0, cmp});
        wr(twfo_pkg::ADDR_CAPTOP, {16'h0, top});
        wr(twfo_pkg::ADDR_COUNT, {16'h0, cnt});
        wr(twfo_pkg::ADDR_FLAGS, 32'h00000007);
        wr(twfo_pkg::ADDR_CTRL, ctrl(cs, com, m));
    endtask
    // High and low widths of one whole pad period, in clock cycles
    task automatic measure();
        int n;
        n = 0;
        hi = 0;
        lo = 0;
        @(negedge core_clk);
        while (padLevel !== 1'b0 && n < 4000) begin
            n++;
            @(negedge core_clk);
        end
        while (padLevel !== 1'b1 && n < 8000) begin
            n++;
            @(negedge core_clk);
        end
        while (padLevel === 1'b1 && hi < 4000) begin
            hi++;
            @(negedge core_clk);
        end
        while (padLevel === 1'b0 && lo < 4000) begin
            lo++;
            @(negedge core_clk);
        end
    endtask
    task automatic wave(input logic [3:0] m, input logic [1:0] com, input logic [2:0] cs,
        input logic [15:0] cmp, input logic [15:0] top, input int ehi, input int elo);
        setup(m, com, cs, cmp, top, 16'h0000);
        measure();
        chk(32'(hi), 32'(ehi));
        chk(32'(lo), 32'(elo));
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_mux();
        rdchk(twfo_pkg::ADDR_CTRL, 32'h00000000);
        chk({31'h0, pready}, 32'h00000001);
        chk({31'h0, portPinOe}, 32'h00000000);
        rdchk(8'h40, 32'h00000000);
        chk({31'h0, err}, 32'h00000001);
        wr(twfo_pkg::ADDR_PORT, 32'h00000003);
        chk({31'h0, padLevel}, 32'h00000001);
        wr(twfo_pkg::ADDR_CTRL, ctrl(3'h0, twfo_pkg::COM_TOGGLE, 4'h0));
        chk({31'h0, padLevel}, 32'h00000000);
        wr(twfo_pkg::ADDR_PORT, 32'h00000001);
        chk({31'h0, portPinOe}, 32'h00000000);
        wr(twfo_pkg::ADDR_PORT, 32'h00000002);
    endtask
    task automatic t_force();
        wr(twfo_pkg::ADDR_COUNT, 32'h00001234);
        wr(twfo_pkg::ADDR_FORCE, 32'h00000001);
        chk({31'h0, padLevel}, 32'h00000001);
        rdchk(twfo_pkg::ADDR_FLAGS, 32'h00000000);
        rdchk(twfo_pkg::ADDR_COUNT, 32'h00001234);
        wr(twfo_pkg::ADDR_CTRL, ctrl(3'h0, twfo_pkg::COM_OFF, 4'h0));
        wr(twfo_pkg::ADDR_FORCE, 32'h00000001);
        wr(twfo_pkg::ADDR_CTRL, ctrl(3'h0, twfo_pkg::COM_TOGGLE, 4'h0));
        chk({31'h0, padLevel}, 32'h00000001);
    endtask
    task automatic t_count();
        setup(twfo_pkg::WGM_NORMAL, 2'h0, twfo_pkg::CS_DIV1, 16'h8000, 16'h0010, 16'hFFF0);
        repeat (20) apb(1'b0, twfo_pkg::ADDR_FLAGS, 32'h0);
        chk(rd & 32'h7, 32'h00000001);
        // Sampled 61 ticks after 0xFFF0 was loaded, so the count has wrapped
        rdchk(twfo_pkg::ADDR_COUNT, 32'h0000002D);
        setup(twfo_pkg::WGM_CTC_CAP, 2'h0, twfo_pkg::CS_DIV1, 16'h8000, 16'h0010, 16'hFFF0);
        repeat (20) apb(1'b0, twfo_pkg::ADDR_FLAGS, 32'h0);
        chk(rd & 32'h7, 32'h00000005);
    endtask
    task automatic t_ctc();
        wave(twfo_pkg::WGM_CTC_CMPA, twfo_pkg::COM_TOGGLE, twfo_pkg::CS_DIV1, 16'h3, 16'h0, 4, 4);
        rdchk(twfo_pkg::ADDR_FLAGS, 32'h00000002);
        wave(twfo_pkg::WGM_CTC_CMPA, twfo_pkg::COM_TOGGLE, twfo_pkg::CS_DIV1, 16'h0, 16'h0, 1, 1);
        wave(twfo_pkg::WGM_CTC_CMPA, twfo_pkg::COM_TOGGLE, twfo_pkg::CS_DIV8, 16'h0, 16'h0, 8, 8);
        wave(twfo_pkg::WGM_CTC_CMPA, twfo_pkg::COM_TOGGLE, twfo_pkg::CS_DIV64, 16'h0, 16'h0, 64, 64);
    endtask
    task automatic t_pwm();
        wave(twfo_pkg::WGM_FAST_8, twfo_pkg::COM_CLEAR, twfo_pkg::CS_DIV1, 16'h80, 16'h0, 127, 129);
        wave(twfo_pkg::WGM_FAST_8, twfo_pkg::COM_SET, twfo_pkg::CS_DIV1, 16'h80, 16'h0, 129, 127);
        wave(twfo_pkg::WGM_FAST_9, twfo_pkg::COM_CLEAR, twfo_pkg::CS_DIV1, 16'h100, 16'h0, 255, 257);
        wave(twfo_pkg::WGM_FAST_10, twfo_pkg::COM_CLEAR, twfo_pkg::CS_DIV1, 16'h200, 16'h0, 511, 513);
        wave(twfo_pkg::WGM_FAST_CAP, twfo_pkg::COM_CLEAR, twfo_pkg::CS_DIV1, 16'h4, 16'h9, 5, 5);
        wave(twfo_pkg::WGM_FAST_CMPA, twfo_pkg::COM_TOGGLE, twfo_pkg::CS_DIV1, 16'h3, 16'h0, 4, 4);
        wr(twfo_pkg::ADDR_CMPA, 32'h00000007);
        rdchk(twfo_pkg::ADDR_CMPA, 32'h00000007);
        measure();
        chk(32'(hi), 32'd8);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset_mux();
        t_force();
        t_count();
        t_ctc();
        t_pwm();
        stop_test();
    end
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
endmodule
